// ### common/dmfs_pkg.sv
// package for the diagnostic mode fault supervisor
package dmfs_pkg;
	// fault reaction codes
	localparam logic [1:0] RX_WARN = 2'b00;
	localparam logic [1:0] RX_ERR  = 2'b01;
	localparam logic [1:0] RX_ARE  = 2'b10;
	localparam logic [1:0] RX_LATCH = 2'b11;
	localparam logic [1:0] RX_DEFAULT = RX_ERR;
	localparam int         N_DIAG  = 4;
	localparam int         N_DOUT  = 2;
	// register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_REACT  = 8'h04;
	localparam logic [7:0] A_STAT   = 8'h08;
	localparam logic [7:0] A_ERRREG = 8'h0c;
	localparam logic [7:0] A_IRQST  = 8'h10;
	localparam logic [7:0] A_IRQMSK = 8'h14;
	// ctrl fields
	localparam int C_SIG    = 0;
	localparam int C_IPVDIS = 1;
	localparam int C_WWDDIS = 2;
	localparam int C_REDOP  = 3;
	// status fields
	localparam int S_WARN   = 0;
	localparam int S_ERR    = 1;
	localparam int S_SPIERR = 2;
	localparam int S_LOCK   = 3;
	localparam int S_MODE   = 4;
	// configuration timeout: 10 ms at 40 ns
	localparam int CFG_TO_US = 10000;
	localparam int CLK_NS    = 40;
	localparam int CFG_TO_CYC = CFG_TO_US * 1000 / CLK_NS;
	localparam logic [31:0] RST_CTRL = 32'h0;
	typedef enum {M_OFF, M_CFG, M_NORM, M_RED, M_LOCK} dmfs_mode_t;
	typedef struct packed {
		logic frame_err;
		logic frame_to;
		logic crc_err;
		logic addr_err;
	} dmfs_spi_ev_t;
endpackage

// ### core/dmfs_core.sv
// diagnostic mode fault supervisor, with AXI4-Lite register slave
// Contract
// - on wake entering configuration, every programmable reaction returns to its default.
// - the fault pin ignores faults in configuration and follows them only in normal mode.
// - successful configuration applies programmed reactions and clears error registers together.
// - in reduced operation some diagnostics are off and readout is limited; the code latches diagnostics, not serial errors, and gates reporting and readout.
// - in reduced operation no fault is reported on the serial side or the fault pin.
// - serial frame, timeout, CRC and address errors are warnings setting the serial-error flag.
// - a configuration timeout locks the device until a wake restart driven by the host.
// - an overloaded digital output is latched high impedance besides its reaction; the code gives an overload no reaction, only the latch.
// - pattern monitor and window watchdog supervision can be disabled during configuration.
// - each diagnostic takes a two-bit reaction: warning, error, auto-restart, latched.
// - the fault pin goes low for error-class faults and stays high for warnings.
// - the warning flag ORs warning faults and clears once gone and error register read.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module dmfs_core
	import dmfs_pkg::*;
#(
	parameter int CFG_TO = CFG_TO_CYC
)(
	// clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_rst_b,
	// pins and detectors
	input  wire logic              i_wake_inhibit_pin,
	input  wire logic [N_DIAG-1:0] i_diag,
	input  wire logic [N_DOUT-1:0] i_dout_ovl,
	input  wire logic              i_ipv_fault,
	input  wire logic              i_wwd_fault,
	input  wire dmfs_spi_ev_t      i_spi_ev,
	// outputs
	output logic                   o_fault_n,
	output logic                   o_fets_off,
	output logic [N_DOUT-1:0]      o_dout_oe,
	output logic                   o_irq,
	// axi4-lite
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [7:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp
);
	localparam int ND = N_DIAG + 2; // diagnostics plus pattern and watchdog

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [ND+N_DOUT:0] s1_q, s2_q;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {i_wake_inhibit_pin, i_dout_ovl, i_wwd_fault, i_ipv_fault, i_diag};
			s2_q <= s1_q;
		end
	end
	wire logic              wake = s2_q[ND+N_DOUT];
	wire logic [N_DOUT-1:0] ovl  = s2_q[ND +: N_DOUT];

	// ****************************************
	// state
	// ****************************************
	dmfs_mode_t        mode_q, mode_d;
	logic [31:0]       cnt_q, cnt_d;
	logic [2*ND-1:0]   react_q, react_d, act_q, act_d;
	logic [3:0]        ctrl_q, ctrl_d;
	logic [ND-1:0]     err_q, err_d;
	logic              spierr_q, spierr_d;
	logic [N_DOUT-1:0] tri_q, tri_d;
	logic              latched_fault_q, latched_fault_d;
	logic [3:0]        ist_q, ist_d, imsk_q, imsk_d;
	logic              aw_q, w_q, bv_q, rv_q;
	logic [7:0]        awa_q;
	logic [31:0]       wd_q, rd_q, rd_d;
	logic              fault_n_q, fets_q, irq_q;

	function automatic logic [1:0] rx_of(input logic [2*ND-1:0] v, input int i);
		return v[2*i +: 2];
	endfunction

	wire logic wr_go = aw_q && w_q && !bv_q;
	wire logic rd_go = s_axi_arvalid && !rv_q;
	logic [ND-1:0] live, wmask, emask, fmask;
	logic          spi_ev;
	logic          err_rd;

	// ****************************************
	// mode, config and fault logic
	// ****************************************
	always_comb begin
		mode_d   = mode_q;
		cnt_d    = cnt_q;
		react_d  = react_q;
		act_d    = act_q;
		ctrl_d   = ctrl_q;
		err_d    = err_q;
		spierr_d = spierr_q;
		tri_d    = tri_q;
		latched_fault_d = latched_fault_q;
		imsk_d   = imsk_q;
		spi_ev   = |i_spi_ev;
		err_rd   = rd_go && (s_axi_araddr == A_ERRREG);
		live     = s2_q[ND-1:0];
		live[N_DIAG]   = live[N_DIAG] & ~ctrl_q[C_IPVDIS];
		live[N_DIAG+1] = live[N_DIAG+1] & ~ctrl_q[C_WWDDIS];
		for (int i = 0; i < ND; i++) begin
			wmask[i] = rx_of(act_q, i) == RX_WARN;
			emask[i] = rx_of(act_q, i) != RX_WARN;
			// only the two codes that switch the bridge off
			fmask[i] = (rx_of(act_q, i) == RX_ARE) || (rx_of(act_q, i) == RX_LATCH);
		end
		// diagnostic detectors still latch in reduced mode, only their reporting is gated; the serial-error flag is not set there
		err_d = (err_rd ? (err_q & live) : err_q) | live;
		if (spi_ev && mode_q != M_RED)
			spierr_d = 1'b1;
		else if (rd_go && s_axi_araddr == A_STAT)
			spierr_d = 1'b0;
		tri_d = tri_q | ovl;
		// a latched error holds until the next wake restart
		if (mode_q == M_NORM) begin
			for (int i = 0; i < ND; i++)
				if (live[i] && rx_of(act_q, i) == RX_LATCH)
					latched_fault_d = 1'b1;
		end
		if (wr_go && awa_q == A_IRQMSK)
			imsk_d = wd_q[3:0];
		case (mode_q)
			M_OFF: begin
				if (wake) begin
					mode_d  = M_CFG;
					react_d = {ND{RX_DEFAULT}};
					act_d   = {ND{RX_DEFAULT}};
					ctrl_d  = RST_CTRL[3:0];
					cnt_d   = '0;
					tri_d   = '0;
					latched_fault_d = 1'b0;
				end
			end
			M_CFG: begin
				cnt_d = cnt_q + 32'd1;
				if (wr_go && awa_q == A_REACT)
					react_d = wd_q[2*ND-1:0];
				if (wr_go && awa_q == A_CTRL) begin
					ctrl_d = wd_q[3:0];
					if (wd_q[C_SIG]) begin
						mode_d = wd_q[C_REDOP] ? M_RED : M_NORM;
						act_d  = react_q;
						err_d  = '0;
					end
				end
				if (cnt_q >= CFG_TO - 1 && mode_d == M_CFG)
					mode_d = M_LOCK;
			end
			M_NORM, M_RED: begin
				if (wr_go && awa_q == A_CTRL)
					mode_d = wd_q[C_REDOP] ? M_RED : M_NORM;
			end
			M_LOCK: ;
			default: mode_d = M_OFF;
		endcase
		if (!wake)
			mode_d = M_OFF;
	end

	// ****************************************
	// reporting: normal-mode gate, error summaries, interrupt status
	// ****************************************
	wire logic rep     = (mode_q == M_NORM);
	wire logic err_any = |(err_q & emask) | latched_fault_q;
	wire logic wrn_any = |(err_q & wmask);
	always_comb begin
		ist_d = ist_q | {mode_q == M_LOCK, rep & spierr_q, rep & err_any, rep & wrn_any};
		if (wr_go && awa_q == A_IRQST)
			ist_d = (ist_q & ~wd_q[3:0]) |
				{mode_q == M_LOCK, rep & spierr_q, rep & err_any, rep & wrn_any};
	end

	// ****************************************
	// pin drive and interrupt line
	// ****************************************
	logic fault_n_d, fets_d, irq_d;
	// pins follow live detections, so they release once the fault is gone, unless a latched reaction holds them until the next wake;
	// the latched error register only feeds the status flags
	always_comb begin
		fault_n_d = !(rep && ((|(live & emask)) || latched_fault_q));
		fets_d    = latched_fault_q || (rep && |(live & fmask));
		irq_d     = |(ist_q & imsk_q);
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		case (s_axi_araddr)
			A_CTRL:   rd_d = {28'h0, ctrl_q};
			A_REACT:  rd_d = {{(32-2*ND){1'b0}}, react_q};
			A_STAT:   rd_d = {25'h0, 3'(mode_q), mode_q == M_LOCK,
					spierr_q & (mode_q != M_RED),
					err_any & (mode_q != M_RED), wrn_any & (mode_q != M_RED)};
			A_ERRREG: rd_d = (mode_q == M_RED) ? 32'h0 : {{(32-ND){1'b0}}, err_q};
			A_IRQST:  rd_d = {28'h0, ist_q};
			A_IRQMSK: rd_d = {28'h0, imsk_q};
			default:  rd_d = 32'h0;
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_q <= M_OFF; cnt_q <= '0; react_q <= '0; act_q <= '0;
			ctrl_q <= '0; err_q <= '0; spierr_q <= 1'b0; tri_q <= '0;
			latched_fault_q <= 1'b0; ist_q <= '0; imsk_q <= '0;
			fault_n_q <= 1'b1; fets_q <= 1'b0; irq_q <= 1'b0;
			aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
			awa_q <= '0; wd_q <= '0; rd_q <= '0;
		end else begin
			mode_q <= mode_d; cnt_q <= cnt_d; react_q <= react_d; act_q <= act_d;
			ctrl_q <= ctrl_d; err_q <= err_d; spierr_q <= spierr_d; tri_q <= tri_d;
			latched_fault_q <= latched_fault_d; ist_q <= ist_d; imsk_q <= imsk_d;
			fault_n_q <= fault_n_d;
			fets_q    <= fets_d;
			irq_q     <= irq_d;
			// axi handshakes
			if (s_axi_awvalid && !aw_q && !bv_q) begin
				aw_q  <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_q && !bv_q) begin
				w_q  <= 1'b1;
				wd_q <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q  <= 1'b0;
				bv_q <= 1'b1;
			end else if (bv_q && s_axi_bready)
				bv_q <= 1'b0;
			if (rd_go) begin
				rv_q <= 1'b1;
				rd_q <= rd_d;
			end else if (rv_q && s_axi_rready)
				rv_q <= 1'b0;
		end
	end

	// outputs
	assign o_fault_n     = fault_n_q;
	assign o_fets_off    = fets_q;
	assign o_dout_oe     = ~tri_q;
	assign o_irq         = irq_q;
	assign s_axi_awready = !aw_q && !bv_q;
	assign s_axi_wready  = !w_q && !bv_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = 2'b00;
	assign s_axi_arready = !rv_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = 2'b00;

	// ****************************************
	// assertions
	// ****************************************
	// a tristated output seen one cycle into a run that is not a fresh configuration
	sequence s_tri_run;
		tri_q != '0 && mode_q != M_OFF ##1 mode_q != M_CFG;
	endsequence
	a_pin_quiet_cfg: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_CFG |=> o_fault_n) else $error("fault pin active in config");
	a_pin_quiet_red: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_RED |=> o_fault_n) else $error("fault pin active in reduced");
	a_cfg_done_clr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_CFG && mode_d == M_NORM |=> err_q == '0 && act_q == $past(react_q))
		else $error("config completion did not clear");
	a_wake_default: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_OFF && wake |=> act_q == {ND{RX_DEFAULT}}) else $error("defaults not loaded");
	a_lock_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_LOCK && wake |=> mode_q == M_LOCK) else $error("lock released without wake");
	a_dout_latched: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		s_tri_run |-> tri_q != '0) else $error("tristate latch lost");
	a_spi_warn: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		spi_ev && mode_q == M_NORM |=> spierr_q) else $error("serial error flag not set");
	a_ipv_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		ctrl_q[C_IPVDIS] && !err_q[N_DIAG] |=> !err_q[N_DIAG]) else $error("pattern monitor not disabled");
	a_err_pin_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_NORM && (live & emask) != '0 |=> !o_fault_n) else $error("error fault not on pin");
	a_fets_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_NORM && (live & fmask) != '0 |=> o_fets_off) else $error("bridge not switched off");
	a_fets_plain_err: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		mode_q == M_NORM && !latched_fault_q && (live & fmask) == '0 |=> !o_fets_off)
		else $error("bridge off without cause");
endmodule

// ### tb/dmfs_host_model.sv
// host model: axi4-lite master driven through tasks
`timescale 1ns/1ps
module dmfs_host_model (
	// clock
	input  wire logic        i_mclk,
	// write side
	output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready,
	output logic [7:0]       s_axi_awaddr,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid,
	input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
	// read side
	output logic             s_axi_arvalid, s_axi_rready,
	output logic [7:0]       s_axi_araddr,
	input  wire logic        s_axi_arready, s_axi_rvalid,
	input  wire logic [31:0] s_axi_rdata
);
	// idle bus; strobe fixed since only full words are written
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
	end
	// write: each channel dropped at its own handshake, then wait for the response
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge i_mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		// extra edge so a following call never re-drives in the same step
		@(posedge i_mclk);
	endtask
	// read: data taken at the edge where rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge i_mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		@(posedge i_mclk);
	endtask
endmodule

// ### tb/dmfs_core_tb_top.sv
// self-checking bench for the diagnostic mode fault supervisor
`timescale 1ns/1ps
module dmfs_core_tb_top
	import dmfs_pkg::*;
;
	// ****************
	// stimulus and wiring
	// ****************
	logic i_mclk = 1'b0, i_rst_b = 1'b0, i_wake_inhibit_pin = 1'b0, i_ipv_fault = 1'b0, i_wwd_fault = 1'b0;
	logic [N_DIAG-1:0] i_diag = '0;
	logic [N_DOUT-1:0] i_dout_ovl = '0;
	dmfs_spi_ev_t      i_spi_ev = '0;
	logic              o_fault_n, o_fets_off, o_irq;
	logic [N_DOUT-1:0] o_dout_oe;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, r;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int mismatches = 0, total_checks = 0, seed = 13;
	always #20 i_mclk = ~i_mclk;
	// short timeout keeps the lock test quick
	dmfs_core #(.CFG_TO(50)) uut (
		.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wake_inhibit_pin(i_wake_inhibit_pin),
		.i_diag(i_diag), .i_dout_ovl(i_dout_ovl), .i_ipv_fault(i_ipv_fault), .i_wwd_fault(i_wwd_fault),
		.i_spi_ev(i_spi_ev), .o_fault_n(o_fault_n), .o_fets_off(o_fets_off), .o_dout_oe(o_dout_oe),
		.o_irq(o_irq), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
	);
	dmfs_host_model host (
		.i_mclk(i_mclk), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_bready(s_axi_bready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_rready(s_axi_rready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata)
	);
	function automatic logic [31:0] react_all(input logic [1:0] c);
		react_all = '0;
		for (int i = 0; i < N_DIAG + 2; i++) react_all[i*2 +: 2] = c;
	endfunction
	// {fets_off, fault_n} for diag[2:0] set as warn, err, auto-restart
	function automatic logic [1:0] pins_exp(input logic [2:0] d);
		return {d[2], !(d[1] | d[2])};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
		logic [31:0] d;
		host.rd(a, d);
		chk(n, e, d & m);
		chk("rresp", 32'h0, {30'h0, s_axi_rresp});
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic wake(input logic v);
		i_wake_inhibit_pin <= v;
		w(5);
	endtask
	task print_verdict;
		if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		w(8);
		i_rst_b <= 1'b1;
		w(1);
		wake(1'b1);
		rc(A_STAT, 32'h70, 32'h10, "mode_cfg");
		rc(A_REACT, 32'hfff, react_all(RX_DEFAULT), "react_default");
		i_diag <= 4'h2;
		w(6);
		chk("fault_n_cfg", 1, o_fault_n);
		rc(A_ERRREG, 32'hf, 32'h2, "err_in_cfg");
		i_diag <= '0;
		host.wr(A_REACT, {20'h0, RX_ERR, RX_ERR, RX_LATCH, RX_ARE, RX_ERR, RX_WARN});
		host.wr(A_CTRL, 32'h3);
		rc(A_ERRREG, 32'hf, 32'h0, "err_cleared");
		rc(A_REACT, 32'hfff, 32'h5e4, "react_applied");
		rc(A_STAT, 32'h70, 32'h20, "mode_norm");
		i_ipv_fault <= 1'b1;
		w(6);
		chk("fault_n_ipv_off", 1, o_fault_n);
		{i_ipv_fault, i_wwd_fault} <= 2'b01;
		w(6);
		chk("fault_n_wwd", 0, o_fault_n);
		i_wwd_fault <= 1'b0;
		// random patterns over the warn, err and auto-restart detectors
		repeat (16) begin
			r = $random(seed);
			i_diag <= {1'b0, r[2:0]};
			w(6);
			chk("pins", pins_exp(r[2:0]), {o_fets_off, o_fault_n});
		end
		i_diag <= 4'h1;
		w(6);
		chk("irq_masked", 0, o_irq);
		host.wr(A_IRQMSK, 32'h1);
		w(2);
		chk("irq_warn", 1, o_irq);
		rc(A_STAT, 32'h1, 32'h1, "warn_flag");
		i_diag <= '0;
		w(6);
		rc(A_STAT, 32'h1, 32'h1, "warn_held");
		host.rd(A_ERRREG, r);
		rc(A_STAT, 32'h1, 32'h0, "warn_clear");
		host.wr(A_IRQST, 32'h1);
		w(2);
		chk("irq_clear", 0, o_irq);
		host.wr(8'h20, 32'hffffffff);
		chk("bresp", 32'h0, {30'h0, s_axi_bresp});
		rc(8'h20, 32'hffffffff, 32'h0, "unmapped");
		for (int k = 0; k < 4; k++) begin
			i_spi_ev <= dmfs_spi_ev_t'(4'h1 << k);
			w(1);
			i_spi_ev <= '0;
			rc(A_STAT, 32'h4, 32'h4, "spi_err_set");
			rc(A_STAT, 32'h4, 32'h0, "spi_err_rd_clr");
		end
		i_dout_ovl <= 2'b01;
		w(6);
		i_dout_ovl <= '0;
		w(6);
		chk("dout_latched", 2'b10, o_dout_oe);
		i_diag <= 4'h8;
		w(6);
		i_diag <= '0;
		w(6);
		chk("latch_pins", 2'b10, {o_fets_off, o_fault_n});
		wake(1'b0);
		wake(1'b1);
		rc(A_REACT, 32'hfff, react_all(RX_DEFAULT), "react_rewake");
		chk("dout_rewake", 2'b11, o_dout_oe);
		chk("fault_n_rewake", 1, o_fault_n);
		w(60);
		rc(A_STAT, 32'h78, 32'h48, "locked");
		wake(1'b0);
		wake(1'b1);
		rc(A_STAT, 32'h78, 32'h10, "unlocked");
		host.wr(A_CTRL, 32'h5);
		i_wwd_fault <= 1'b1;
		w(6);
		chk("fault_n_wwd_off", 1, o_fault_n);
		i_wwd_fault <= 1'b0;
		host.wr(A_CTRL, 32'h8);
		rc(A_STAT, 32'h70, 32'h30, "mode_red");
		i_diag <= 4'h2;
		w(6);
		chk("fault_n_red", 1, o_fault_n);
		rc(A_ERRREG, 32'hf, 32'h0, "err_red");
		print_verdict();
	end
	// watchdog, well beyond the roughly 360 cycles of the sequence
	initial begin
		w(4000);
		mismatches++;
		print_verdict();
	end
endmodule
